// >>> hw/gpasc_pkg.sv
// constants and types for the atomic gpio set/clear block
package gpasc_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [31:0] GPASC_P0_DAT_ADDR = 32'hFFFF0D20;
	localparam logic [31:0] GPASC_P0_SET_ADDR = 32'hFFFF0D24;
	localparam logic [31:0] GPASC_P0_CLR_ADDR = 32'hFFFF0D28;
	localparam logic [31:0] GPASC_P1_DAT_ADDR = 32'hFFFF0D30;
	localparam logic [31:0] GPASC_P1_SET_ADDR = 32'hFFFF0D34;
	localparam logic [31:0] GPASC_P1_CLR_ADDR = 32'hFFFF0D38;
	localparam logic [31:0] GPASC_P2_DAT_ADDR = 32'hFFFF0D40;
	localparam logic [31:0] GPASC_P2_SET_ADDR = 32'hFFFF0D44;
	localparam logic [31:0] GPASC_P2_CLR_ADDR = 32'hFFFF0D48;

	// ----------------------------------------
	// field layout of the data register; set and clear use only the output field
	// ----------------------------------------
	localparam int GPASC_NPORT = 3;
	localparam int GPASC_FW = 8;
	localparam int GPASC_IN_LSB = 0;
	localparam int GPASC_OUT_LSB = 16;
	localparam int GPASC_DIR_LSB = 24;
	localparam logic [7:0] GPASC_P0_MASK = 8'h1F;
	localparam logic [7:0] GPASC_P1_MASK = 8'h03;
	localparam logic [7:0] GPASC_P2_MASK = 8'h63;
	localparam logic [7:0] GPASC_OUT_RST = 8'h00;
	localparam logic [7:0] GPASC_DIR_RST = 8'h00;
	localparam logic [31:0] GPASC_RD_ZERO = 32'h00000000;

	typedef logic [GPASC_FW-1:0] gpasc_field_t;
	typedef enum {GPASC_REG_NONE, GPASC_REG_DAT, GPASC_REG_SET, GPASC_REG_CLR} gpasc_kind_t;

	function automatic logic [7:0] gpasc_mask(input int p);
		case (p)
			0: gpasc_mask = GPASC_P0_MASK;
			1: gpasc_mask = GPASC_P1_MASK;
			default: gpasc_mask = GPASC_P2_MASK;
		endcase
	endfunction

	function automatic gpasc_field_t gpasc_out_field(input logic [31:0] w);
		gpasc_out_field = w[GPASC_OUT_LSB +: GPASC_FW];
	endfunction

endpackage

// >>> hw/gpasc_port_if.sv
// carrier between the bus front end and one port latch
interface gpasc_port_if;
	import gpasc_pkg::*;
	logic [31:0] wr_data;
	logic set_stb;
	logic clr_stb;
	logic dat_stb;
	gpasc_field_t pad_in;
	gpasc_field_t out_q;
	gpasc_field_t dir_q;
	gpasc_field_t in_q;

	modport ctrl (
		output wr_data,
		output set_stb,
		output clr_stb,
		output dat_stb,
		output pad_in,
		input out_q,
		input dir_q,
		input in_q
	);
	modport port (
		input wr_data,
		input set_stb,
		input clr_stb,
		input dat_stb,
		input pad_in,
		output out_q,
		output dir_q,
		output in_q
	);
endinterface

// >>> hw/gpasc_port.sv
// one gpio port: output latch, direction bits, input synchroniser
module gpasc_port #(
	parameter logic [7:0] PIN_MASK = 8'h1F
) (
	input wire logic mclk,
	input wire logic rst_n,
	gpasc_port_if.port pif
);
	import gpasc_pkg::*;

	generate
		if (PIN_MASK == 8'h00) begin : g_bad_mask
			$error("gpasc_port: PIN_MASK selects no pin");
		end
	endgenerate

	gpasc_field_t out_reg;
	gpasc_field_t out_next;
	gpasc_field_t dir_reg;
	gpasc_field_t sync1_reg;
	gpasc_field_t sync2_reg;
	gpasc_field_t field;

	assign field = gpasc_out_field(pif.wr_data) & PIN_MASK;

	// ----------------------------------------
	// output latch
	// ----------------------------------------
	always_comb begin
		out_next = out_reg;
		if (pif.dat_stb) begin
			out_next = field;
		end else if (pif.set_stb) begin
			out_next = out_reg | field;
		end else if (pif.clr_stb) begin
			out_next = out_reg & ~field;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= GPASC_OUT_RST;
		end else begin
			out_reg <= out_next;
		end
	end

	// ----------------------------------------
	// direction bits
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg <= GPASC_DIR_RST;
		end else if (pif.dat_stb) begin
			dir_reg <= pif.wr_data[GPASC_DIR_LSB +: GPASC_FW] & PIN_MASK;
		end
	end

	// ----------------------------------------
	// pad input synchroniser
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= GPASC_OUT_RST;
			sync2_reg <= GPASC_OUT_RST;
		end else begin
			sync1_reg <= pif.pad_in;
			sync2_reg <= sync1_reg & PIN_MASK;
		end
	end

	assign pif.out_q = out_reg;
	assign pif.dir_q = dir_reg;
	assign pif.in_q = sync2_reg;

endmodule

// >>> hw/gpasc_top.sv
// apb front end and pad mapping for the three gpio ports
module gpasc_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [4:0] port0_pad_in,
	output logic [4:0] port0_pad_out,
	output logic [4:0] port0_pad_oe_n,
	input wire logic [1:0] port1_pad_in,
	output logic [1:0] port1_pad_out,
	output logic [1:0] port1_pad_oe_n,
	input wire logic [3:0] port2_pad_in,
	output logic [3:0] port2_pad_out,
	output logic [3:0] port2_pad_oe_n
);
	import gpasc_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_meta_n_reg;
	logic rst_sync_n_reg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n_reg <= 1'b0;
			rst_sync_n_reg <= 1'b0;
		end else begin
			rst_meta_n_reg <= 1'b1;
			rst_sync_n_reg <= rst_meta_n_reg;
		end
	end

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	gpasc_kind_t dec_kind;
	logic [1:0] dec_port;
	logic wr_en;
	logic rd_setup;
	logic acc_err;
	logic [31:0] rd_next;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	always_comb begin
		dec_kind = GPASC_REG_NONE;
		dec_port = 2'h0;
		case (paddr)
			GPASC_P0_DAT_ADDR: begin
				dec_kind = GPASC_REG_DAT;
				dec_port = 2'h0;
			end
			GPASC_P0_SET_ADDR: begin
				dec_kind = GPASC_REG_SET;
				dec_port = 2'h0;
			end
			GPASC_P0_CLR_ADDR: begin
				dec_kind = GPASC_REG_CLR;
				dec_port = 2'h0;
			end
			GPASC_P1_DAT_ADDR: begin
				dec_kind = GPASC_REG_DAT;
				dec_port = 2'h1;
			end
			GPASC_P1_SET_ADDR: begin
				dec_kind = GPASC_REG_SET;
				dec_port = 2'h1;
			end
			GPASC_P1_CLR_ADDR: begin
				dec_kind = GPASC_REG_CLR;
				dec_port = 2'h1;
			end
			GPASC_P2_DAT_ADDR: begin
				dec_kind = GPASC_REG_DAT;
				dec_port = 2'h2;
			end
			GPASC_P2_SET_ADDR: begin
				dec_kind = GPASC_REG_SET;
				dec_port = 2'h2;
			end
			GPASC_P2_CLR_ADDR: begin
				dec_kind = GPASC_REG_CLR;
				dec_port = 2'h2;
			end
			default: begin
				dec_kind = GPASC_REG_NONE;
				dec_port = 2'h0;
			end
		endcase
	end

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && pready && (pstrb == 4'hF) && (dec_kind != GPASC_REG_NONE);
	assign rd_setup = psel && !penable && !pwrite;
	// unmapped address or partial-word write is refused with an error
	assign acc_err = (dec_kind == GPASC_REG_NONE) || (pwrite && (pstrb != 4'hF));

	// ----------------------------------------
	// port latches
	// ----------------------------------------
	gpasc_port_if pif[GPASC_NPORT] ();

	generate
		for (genvar gi = 0; gi < GPASC_NPORT; gi++) begin : g_port
			assign pif[gi].wr_data = pwdata;
			assign pif[gi].set_stb = wr_en && (dec_kind == GPASC_REG_SET) && (dec_port == 2'(gi));
			assign pif[gi].clr_stb = wr_en && (dec_kind == GPASC_REG_CLR) && (dec_port == 2'(gi));
			assign pif[gi].dat_stb = wr_en && (dec_kind == GPASC_REG_DAT) && (dec_port == 2'(gi));
			gpasc_port #(
				.PIN_MASK(gpasc_mask(gi))
			) u_port (
				.mclk(mclk),
				.rst_n(rst_sync_n_reg),
				.pif(pif[gi])
			);
		end
	endgenerate

	assign pif[0].pad_in = {3'h0, port0_pad_in};
	assign pif[1].pad_in = {6'h00, port1_pad_in};
	assign pif[2].pad_in = {1'b0, port2_pad_in[3:2], 3'h0, port2_pad_in[1:0]};

	// ----------------------------------------
	// pads
	// ----------------------------------------
	assign port0_pad_out = pif[0].out_q[4:0];
	assign port0_pad_oe_n = ~pif[0].dir_q[4:0];
	assign port1_pad_out = pif[1].out_q[1:0];
	assign port1_pad_oe_n = ~pif[1].dir_q[1:0];
	assign port2_pad_out = {pif[2].out_q[6:5], pif[2].out_q[1:0]};
	assign port2_pad_oe_n = ~{pif[2].dir_q[6:5], pif[2].dir_q[1:0]};

	// ----------------------------------------
	// read data and error
	// ----------------------------------------
	gpasc_field_t sel_out;
	gpasc_field_t sel_dir;
	gpasc_field_t sel_in;

	always_comb begin
		case (dec_port)
			2'h0: begin
				sel_out = pif[0].out_q;
				sel_dir = pif[0].dir_q;
				sel_in = pif[0].in_q;
			end
			2'h1: begin
				sel_out = pif[1].out_q;
				sel_dir = pif[1].dir_q;
				sel_in = pif[1].in_q;
			end
			default: begin
				sel_out = pif[2].out_q;
				sel_dir = pif[2].dir_q;
				sel_in = pif[2].in_q;
			end
		endcase
	end

	always_comb begin
		rd_next = GPASC_RD_ZERO;
		if (dec_kind == GPASC_REG_DAT) begin
			rd_next[GPASC_DIR_LSB +: GPASC_FW] = sel_dir;
			rd_next[GPASC_OUT_LSB +: GPASC_FW] = sel_out;
			rd_next[GPASC_IN_LSB +: GPASC_FW] = sel_in;
		end
	end

	// read data is captured in the setup cycle; set and clear read as zero
	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			prdata_reg <= GPASC_RD_ZERO;
		end else if (rd_setup) begin
			prdata_reg <= rd_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			pslverr_reg <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_reg <= acc_err;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg && psel && penable;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic [31:0] past_addr;
	logic past_wr;

	always_ff @(posedge mclk or negedge rst_sync_n_reg) begin
		if (!rst_sync_n_reg) begin
			past_addr <= GPASC_RD_ZERO;
			past_wr <= 1'b0;
		end else begin
			past_addr <= paddr;
			past_wr <= wr_en;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_sync_n_reg);

	// port2 pins 6,5,1,0 of one field, in pad order
	function automatic logic [3:0] pack_p2(input logic [31:0] w, input int lsb);
		pack_p2 = {w[lsb+6], w[lsb+5], w[lsb+1], w[lsb]};
	endfunction

	// ----------------------------------------
	// set and clear
	// ----------------------------------------
	port0_set_a: assert property (
		past_wr && past_addr == GPASC_P0_SET_ADDR |->
		port0_pad_out == ($past(port0_pad_out) | $past(pwdata[20:16])))
		else $error("port0 set did not raise the selected pins");

	set_zero_keep_a: assert property (
		wr_en && dec_kind == GPASC_REG_SET && pwdata[23:16] == 8'h00 |=>
		$stable(port0_pad_out) && $stable(port1_pad_out) && $stable(port2_pad_out))
		else $error("set write of zeros changed a pin");

	port1_set_a: assert property (
		past_wr && past_addr == GPASC_P1_SET_ADDR |->
		port1_pad_out == ($past(port1_pad_out) | $past(pwdata[17:16])))
		else $error("port1 set did not raise the selected pins");

	port2_set_a: assert property (
		past_wr && past_addr == GPASC_P2_SET_ADDR |->
		port2_pad_out == ($past(port2_pad_out) | pack_p2($past(pwdata), GPASC_OUT_LSB)))
		else $error("port2 set did not raise the selected pins");

	port0_clear_a: assert property (
		past_wr && past_addr == GPASC_P0_CLR_ADDR |->
		port0_pad_out == ($past(port0_pad_out) & ~$past(pwdata[20:16])))
		else $error("port0 clear did not lower the selected pins");

	port1_clear_a: assert property (
		past_wr && past_addr == GPASC_P1_CLR_ADDR |->
		port1_pad_out == ($past(port1_pad_out) & ~$past(pwdata[17:16])))
		else $error("port1 clear did not lower the selected pins");

	port2_clear_a: assert property (
		wr_en && paddr == GPASC_P2_CLR_ADDR |=>
		port2_pad_out == ($past(port2_pad_out) & ~pack_p2($past(pwdata), GPASC_OUT_LSB)))
		else $error("port2 clear did not lower the selected pins");

	clear_zero_keep_a: assert property (
		wr_en && dec_kind == GPASC_REG_CLR && pwdata[23:16] == 8'h00 |=>
		$stable(port0_pad_out) && $stable(port1_pad_out) && $stable(port2_pad_out))
		else $error("clear write of zeros changed a pin");

	other_ports_a: assert property (
		wr_en && dec_kind != GPASC_REG_DAT && dec_port != 2'h1 |=>
		$stable(port1_pad_out) && $stable(port1_pad_oe_n))
		else $error("write to another port disturbed port1");

	port0_keep_a: assert property (
		wr_en && dec_kind != GPASC_REG_DAT && dec_port != 2'h0 |=>
		$stable(port0_pad_out) && $stable(port0_pad_oe_n))
		else $error("write to another port disturbed port0");

	port2_keep_a: assert property (
		wr_en && dec_kind != GPASC_REG_DAT && dec_port != 2'h2 |=>
		$stable(port2_pad_out) && $stable(port2_pad_oe_n))
		else $error("write to another port disturbed port2");

	refused_keep_a: assert property (
		psel && penable && acc_err |=>
		$stable(port0_pad_out) && $stable(port1_pad_out) && $stable(port2_pad_out))
		else $error("refused access changed a pin");

	one_cycle_a: assert property (
		wr_en && dec_kind == GPASC_REG_CLR && dec_port == 2'h0 |=>
		(port0_pad_out & $past(pwdata[20:16])) == 5'h00)
		else $error("clear took more than one cycle");

	// ----------------------------------------
	// data and direction
	// ----------------------------------------
	port0_data_a: assert property (
		wr_en && paddr == GPASC_P0_DAT_ADDR |=>
		port0_pad_out == $past(pwdata[20:16]))
		else $error("port0 pad does not show its data field");

	port1_data_a: assert property (
		wr_en && paddr == GPASC_P1_DAT_ADDR |=>
		port1_pad_out == $past(pwdata[17:16]))
		else $error("port1 pad does not show its data field");

	port2_data_a: assert property (
		wr_en && paddr == GPASC_P2_DAT_ADDR |=>
		port2_pad_out == pack_p2($past(pwdata), GPASC_OUT_LSB))
		else $error("port2 pad does not show its data field");

	port0_dir_a: assert property (
		wr_en && paddr == GPASC_P0_DAT_ADDR |=>
		port0_pad_oe_n == ~$past(pwdata[28:24]))
		else $error("port0 direction write not seen on enables");

	port1_dir_a: assert property (
		wr_en && paddr == GPASC_P1_DAT_ADDR |=>
		port1_pad_oe_n == ~$past(pwdata[25:24]))
		else $error("port1 direction write not seen on enables");

	dir_set_a: assert property (
		wr_en && paddr == GPASC_P2_DAT_ADDR |=>
		port2_pad_oe_n == ~pack_p2($past(pwdata), GPASC_DIR_LSB))
		else $error("port2 direction write not seen on enables");

	readback_a: assert property (
		wr_en && paddr == GPASC_P0_SET_ADDR ##1 psel && !penable && !pwrite &&
		paddr == GPASC_P0_DAT_ADDR |=> prdata[20:16] == port0_pad_out)
		else $error("data register does not reflect the set write");

	// ----------------------------------------
	// bus side
	// ----------------------------------------
	write_only_a: assert property (
		psel && !penable && !pwrite && (dec_kind == GPASC_REG_SET || dec_kind == GPASC_REG_CLR) |=>
		prdata == GPASC_RD_ZERO)
		else $error("set or clear register read back non-zero");

	set_write_c: cover property (wr_en && dec_kind == GPASC_REG_SET && pwdata[23:16] != 8'h00);
	clear_write_c: cover property (wr_en && dec_kind == GPASC_REG_CLR && pwdata[23:16] != 8'h00);
	set_then_clear_c: cover property (wr_en && dec_kind == GPASC_REG_SET ##1 wr_en && dec_kind == GPASC_REG_CLR);
	set_then_read_c: cover property (wr_en && dec_kind == GPASC_REG_SET ##1 psel && !pwrite && dec_kind == GPASC_REG_DAT);
	unmapped_c: cover property (pslverr);

endmodule

// >>> dv/tb_gpasc_top.sv
// self-checking bench for the atomic gpio set/clear block
module tb_gpasc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gpasc_pkg::*;

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end

	typedef struct {
		logic [31:0] a;
		logic [31:0] d;
		logic [4:0] e0;
		logic [1:0] e1;
		logic [3:0] e2;
	} gpasc_row_t;

	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h00000000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic [4:0] port0_pad_in = 5'h15;
	logic [1:0] port1_pad_in = 2'h1;
	logic [3:0] port2_pad_in = 4'hA;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] port0_pad_out;
	logic [4:0] port0_pad_oe_n;
	logic [1:0] port1_pad_out;
	logic [1:0] port1_pad_oe_n;
	logic [3:0] port2_pad_out;
	logic [3:0] port2_pad_oe_n;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	bit held = 1'b0;
	logic [31:0] rd;
	logic err;

	gpasc_row_t rows [12] = '{
		'{GPASC_P0_SET_ADDR, 32'h001F0000, 5'h1F, 2'h0, 4'h0},
		'{GPASC_P1_SET_ADDR, 32'h00030000, 5'h1F, 2'h3, 4'h0},
		'{GPASC_P2_SET_ADDR, 32'h00630000, 5'h1F, 2'h3, 4'hF},
		'{GPASC_P0_CLR_ADDR, 32'h00150000, 5'h0A, 2'h3, 4'hF},
		'{GPASC_P1_CLR_ADDR, 32'h00010000, 5'h0A, 2'h2, 4'hF},
		'{GPASC_P2_CLR_ADDR, 32'h00420000, 5'h0A, 2'h2, 4'h5},
		'{GPASC_P0_SET_ADDR, 32'h00010000, 5'h0B, 2'h2, 4'h5},
		'{GPASC_P2_SET_ADDR, 32'h00400000, 5'h0B, 2'h2, 4'hD},
		'{GPASC_P1_SET_ADDR, 32'h00000000, 5'h0B, 2'h2, 4'hD},
		'{GPASC_P0_CLR_ADDR, 32'h00000000, 5'h0B, 2'h2, 4'hD},
		'{GPASC_P2_CLR_ADDR, 32'h00010000, 5'h0B, 2'h2, 4'hC},
		'{GPASC_P1_CLR_ADDR, 32'h00020000, 5'h0B, 2'h0, 4'hC}
	};

	gpasc_top i_dut (
		.mclk(mclk),
		.rst_n(rst_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.port0_pad_in(port0_pad_in),
		.port0_pad_out(port0_pad_out),
		.port0_pad_oe_n(port0_pad_oe_n),
		.port1_pad_in(port1_pad_in),
		.port1_pad_out(port1_pad_out),
		.port1_pad_oe_n(port1_pad_oe_n),
		.port2_pad_in(port2_pad_in),
		.port2_pad_out(port2_pad_out),
		.port2_pad_oe_n(port2_pad_oe_n)
	);

	// ----------------------------------------
	// clock, timeout, verdict
	// ----------------------------------------
	initial begin
		forever #5 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// apb master and pad checks
	// ----------------------------------------
	// hold keeps psel up so the next setup follows the access at once
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
		input bit hold, output logic [31:0] r, output logic e);
		if (!held) @(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		if (!hold) begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
		held = hold;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, 4'hF, 1'b0, r, e);
		`CHK("pslverr", 1'b0, e)
	endtask

	task automatic pads(input logic [4:0] e0, input logic [1:0] e1, input logic [3:0] e2);
		#1;
		`CHK("port0_pad_out", e0, port0_pad_out)
		`CHK("port1_pad_out", e1, port1_pad_out)
		`CHK("port2_pad_out", e2, port2_pad_out)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		pads(5'h00, 2'h0, 4'h0);
		`CHK("oe_n", 11'h7FF, {port0_pad_oe_n, port1_pad_oe_n, port2_pad_oe_n})
		wr(GPASC_P0_DAT_ADDR, 32'h1F000000);
		wr(GPASC_P1_DAT_ADDR, 32'h03000000);
		wr(GPASC_P2_DAT_ADDR, 32'h63000000);
		#1;
		`CHK("oe_n", 11'h000, {port0_pad_oe_n, port1_pad_oe_n, port2_pad_oe_n})
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			pads(rows[i].e0, rows[i].e1, rows[i].e2);
		end
		apb(GPASC_P0_SET_ADDR, 1'b0, 32'h00000000, 4'hF, 1'b0, rd, err);
		`CHK("set readback", GPASC_RD_ZERO, rd)
		`CHK("set read err", 1'b0, err)
		apb(GPASC_P0_DAT_ADDR, 1'b0, 32'h00000000, 4'hF, 1'b0, rd, err);
		`CHK("port0 data", 32'h1F0B0015, {rd[31:16], 8'h00, rd[7:0]})
		apb(GPASC_P2_DAT_ADDR, 1'b0, 32'h00000000, 4'hF, 1'b0, rd, err);
		`CHK("port2 data", 32'h63600042, {rd[31:16], 8'h00, rd[7:0]})
		apb(32'hFFFF0D2C, 1'b1, 32'h00FF0000, 4'hF, 1'b0, rd, err);
		`CHK("unmapped err", 1'b1, err)
		pads(5'h0B, 2'h0, 4'hC);
		apb(GPASC_P0_CLR_ADDR, 1'b1, 32'h001F0000, 4'h3, 1'b0, rd, err);
		`CHK("partial err", 1'b1, err)
		pads(5'h0B, 2'h0, 4'hC);
		// set then clear with no idle cycle between them
		apb(GPASC_P0_SET_ADDR, 1'b1, 32'h001F0000, 4'hF, 1'b1, rd, err);
		apb(GPASC_P0_CLR_ADDR, 1'b1, 32'h00100000, 4'hF, 1'b0, rd, err);
		pads(5'h0F, 2'h0, 4'hC);
		// set, then read the data register with no idle cycle between them
		apb(GPASC_P0_SET_ADDR, 1'b1, 32'h00100000, 4'hF, 1'b1, rd, err);
		apb(GPASC_P0_DAT_ADDR, 1'b0, 32'h00000000, 4'hF, 1'b0, rd, err);
		`CHK("set readback out", 5'h1F, rd[20:16])
		wr(GPASC_P0_DAT_ADDR, 32'h1F0A0000);
		pads(5'h0A, 2'h0, 4'hC);
		wr(GPASC_P0_DAT_ADDR, 32'h00000000);
		#1;
		`CHK("port0_pad_oe_n", 5'h1F, port0_pad_oe_n)
		@(posedge mclk);
		rst_n <= 1'b0;
		#1;
		`CHK("reset out", 11'h000, {port0_pad_out, port1_pad_out, port2_pad_out})
		`CHK("reset oe_n", 11'h7FF, {port0_pad_oe_n, port1_pad_oe_n, port2_pad_oe_n})
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		wr(GPASC_P1_SET_ADDR, 32'h00020000);
		pads(5'h00, 2'h2, 4'h0);
		wrap_up();
	end

endmodule
